// >>> rtl/bcc_charger_ctrl.sv
// Purpose: Charger control register one and the charge sequencing it steers
// Assumes: Register port and status inputs synchronous to i_clk
// Notes: Mask-programmed defaults are parameters of this module
//
// What this block does
// - Request bit 15 zeroes current when clear, enables charge control when set.
// - Key-protected fields write only when unlocked; marked fields reset by power sequencer.
// - Bits 12:10 select termination current, 20mA plus 10mA per code step.
// - Bit 9 enables thermal choking during trickle charge; reset value zero.
// - Bit 8 enables USB supply choking during trickle charge.
// - Bit 7 picks choke recovery time constant: 180us clear, over 20ms set.
// - Bit 6 clear zeroes current at end of fast charge; set keeps fast charging until timeout.
// - Bit 5 permits fast charge, starting only once valid conditions hold.
// - Fast enable held zero, writes ignored, until fast-ready has gone high.
// - Bit 4 enables USB supply throttling while fast charging.
// - Bit 3, default one, makes charger act on missing thermistor.
// - Bit 2, default one, makes charger monitor battery too hot.
// - Bit 1, default one, makes charger monitor battery too cold.
// - Bit 0, default one, makes charger monitor die temperature.
// - Request, fast enable and monitor defaults come from mask constants.
// - Request only asks; conditions decide, active status reported separately.
`timescale 1ns/1ps
module bcc_charger_ctrl
  import bcc_pkg::*;
#(
  parameter logic MASK_REQ = 1'b1, // Mask default, arbitrary metal option
  parameter logic MASK_FAST = 1'b0, // Mask default of fast enable
  parameter logic [3:0] MASK_MON = 4'hf, // Mask defaults of monitor enables
  parameter int SHORT_CYC = BCC_TC_SHORT_CYC,
  parameter int LONG_CYC = BCC_TC_LONG_CYC
) (
  input wire logic i_clk, // 25 MHz system clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic [7:0] i_reg_addr, // Register address
  input wire logic i_reg_wr, // Write strobe, one cycle
  input wire logic i_reg_rd, // Read strobe, one cycle
  input wire logic [15:0] i_reg_wdata, // Write data
  output logic [15:0] o_reg_rdata, // Read data, held until next read
  output logic o_reg_rvalid, // Read data valid pulse
  input wire logic i_key_unlocked, // Security key open
  input wire logic i_psm_reset, // Power sequencer field reset pulse
  input wire logic i_fast_ready, // Fast charge ready indication
  input wire logic i_cond_ok, // Supply and battery allow charging
  input wire logic i_fast_cond, // Conditions valid for fast charge
  input wire logic i_thermistor_missing, // No thermistor detected
  input wire logic i_batt_hot, // Battery too hot
  input wire logic i_batt_cold, // Battery too cold
  input wire logic i_die_hot, // Die temperature too high
  input wire logic i_temp_high, // Temperature choke demand
  input wire logic i_usb_limit, // USB supply at its current limit
  input wire logic i_eoc_reached, // Current fell to termination level
  input wire logic i_timeout, // Charge timeout expired
  output logic o_charging_active_status, // Charging actually runs
  output logic o_current_en, // Charger current allowed
  output logic o_trickle_mode, // In trickle charge
  output logic o_fast_mode, // In fast charge
  output logic [6:0] o_term_current_ma, // Termination current in mA
  output logic o_thermal_choke, // Apply thermal choking
  output logic o_usb_choke, // Apply USB supply choking
  output logic o_usb_throttle, // Apply USB supply throttling
  output logic o_choke_recovering // Current stepping up after choke
);

  // Register fields
  logic charge_request_q, charge_request_d;
  logic [2:0] termination_current_select_q, termination_current_select_d;
  logic trickle_thermal_choke_en_q, trickle_thermal_choke_en_d;
  logic trickle_usbsupply_choke_en_q, trickle_usbsupply_choke_en_d;
  logic choke_recovery_tc_select_q, choke_recovery_tc_select_d;
  logic end_of_charge_action_q, end_of_charge_action_d;
  logic fast_charge_en_q, fast_charge_en_d;
  logic fast_usbsupply_throttle_en_q, fast_usbsupply_throttle_en_d;
  logic thermistor_monitor_en_q, thermistor_monitor_en_d;
  logic battery_hot_monitor_en_q, battery_hot_monitor_en_d;
  logic battery_cold_monitor_en_q, battery_cold_monitor_en_d;
  logic die_temp_monitor_en_q, die_temp_monitor_en_d;
  logic fast_ready_seen_q, fast_ready_seen_d;

  logic hit, wr_hit, wr_prot;

  // Termination current from code: base plus code steps
  function automatic logic [6:0] eoc_ma(input logic [2:0] code);
    logic [6:0] steps;
    steps = 7'(code) * BCC_EOC_STEP_MA;
    eoc_ma = BCC_EOC_BASE_MA + steps;
  endfunction

  // Any enabled monitor reporting a fault
  function automatic logic fault(input logic [3:0] en, input logic [3:0] cond);
    fault = |(en & cond);
  endfunction

  // Register image for reads
  function automatic logic [15:0] image(
    input logic req, input logic [2:0] eoc, input logic [9:0] low);
    image = {req, 2'b00, eoc, low};
  endfunction

  assign hit = (i_reg_addr == BCC_CTRL1_OFFSET);
  assign wr_hit = i_reg_wr && hit;
  assign wr_prot = wr_hit && i_key_unlocked;

  // Next field values: write, then power sequencer reset
  always_comb begin
    charge_request_d = charge_request_q;
    termination_current_select_d = termination_current_select_q;
    trickle_thermal_choke_en_d = trickle_thermal_choke_en_q;
    trickle_usbsupply_choke_en_d = trickle_usbsupply_choke_en_q;
    choke_recovery_tc_select_d = choke_recovery_tc_select_q;
    end_of_charge_action_d = end_of_charge_action_q;
    fast_charge_en_d = fast_charge_en_q;
    fast_usbsupply_throttle_en_d = fast_usbsupply_throttle_en_q;
    thermistor_monitor_en_d = thermistor_monitor_en_q;
    battery_hot_monitor_en_d = battery_hot_monitor_en_q;
    battery_cold_monitor_en_d = battery_cold_monitor_en_q;
    die_temp_monitor_en_d = die_temp_monitor_en_q;
    fast_ready_seen_d = fast_ready_seen_q | i_fast_ready;
    if (wr_prot) begin
      charge_request_d = i_reg_wdata[BCC_REQ_BIT];
      termination_current_select_d = i_reg_wdata[BCC_EOC_MSB:BCC_EOC_LSB];
      trickle_thermal_choke_en_d = i_reg_wdata[BCC_TCHOKE_BIT];
      trickle_usbsupply_choke_en_d = i_reg_wdata[BCC_UCHOKE_BIT];
      choke_recovery_tc_select_d = i_reg_wdata[BCC_RECOV_BIT];
      end_of_charge_action_d = i_reg_wdata[BCC_ENDACT_BIT];
      fast_usbsupply_throttle_en_d = i_reg_wdata[BCC_THROT_BIT];
      die_temp_monitor_en_d = i_reg_wdata[BCC_DIE_BIT];
      if (fast_ready_seen_q) begin
        fast_charge_en_d = i_reg_wdata[BCC_FAST_BIT];
      end
    end
    // Thermistor and battery temperature monitors carry no key protection
    if (wr_hit) begin
      thermistor_monitor_en_d = i_reg_wdata[BCC_NTC_BIT];
      battery_hot_monitor_en_d = i_reg_wdata[BCC_HOT_BIT];
      battery_cold_monitor_en_d = i_reg_wdata[BCC_COLD_BIT];
    end
    // Sequencer reset returns its marked fields to defaults
    if (i_psm_reset) begin
      charge_request_d = MASK_REQ;
      trickle_thermal_choke_en_d = BCC_BIT_RESET;
      trickle_usbsupply_choke_en_d = BCC_BIT_RESET;
      choke_recovery_tc_select_d = BCC_BIT_RESET;
      end_of_charge_action_d = BCC_BIT_RESET;
      fast_charge_en_d = MASK_FAST;
      fast_usbsupply_throttle_en_d = BCC_BIT_RESET;
    end
    // Held low until fast-ready has been seen, whatever else happened
    if (!fast_ready_seen_q) begin
      fast_charge_en_d = 1'b0;
      if (i_fast_ready) begin
        fast_charge_en_d = MASK_FAST;
      end
    end
  end

  // Field registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      charge_request_q <= MASK_REQ;
      termination_current_select_q <= BCC_EOC_RESET;
      trickle_thermal_choke_en_q <= BCC_BIT_RESET;
      trickle_usbsupply_choke_en_q <= BCC_BIT_RESET;
      choke_recovery_tc_select_q <= BCC_BIT_RESET;
      end_of_charge_action_q <= BCC_BIT_RESET;
      fast_charge_en_q <= 1'b0;
      fast_usbsupply_throttle_en_q <= BCC_BIT_RESET;
      thermistor_monitor_en_q <= MASK_MON[BCC_NTC_BIT];
      battery_hot_monitor_en_q <= MASK_MON[BCC_HOT_BIT];
      battery_cold_monitor_en_q <= MASK_MON[BCC_COLD_BIT];
      die_temp_monitor_en_q <= MASK_MON[BCC_DIE_BIT];
      fast_ready_seen_q <= 1'b0;
    end else begin
      charge_request_q <= charge_request_d;
      termination_current_select_q <= termination_current_select_d;
      trickle_thermal_choke_en_q <= trickle_thermal_choke_en_d;
      trickle_usbsupply_choke_en_q <= trickle_usbsupply_choke_en_d;
      choke_recovery_tc_select_q <= choke_recovery_tc_select_d;
      end_of_charge_action_q <= end_of_charge_action_d;
      fast_charge_en_q <= fast_charge_en_d;
      fast_usbsupply_throttle_en_q <= fast_usbsupply_throttle_en_d;
      thermistor_monitor_en_q <= thermistor_monitor_en_d;
      battery_hot_monitor_en_q <= battery_hot_monitor_en_d;
      battery_cold_monitor_en_q <= battery_cold_monitor_en_d;
      die_temp_monitor_en_q <= die_temp_monitor_en_d;
      fast_ready_seen_q <= fast_ready_seen_d;
    end
  end

  // Read port: captured on the strobe, so data stands until the next read
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = i_reg_rd;
    if (i_reg_rd) begin
      rdata_d = '0; // Unmapped address reads zero
      if (hit) begin
        rdata_d = image(charge_request_q, termination_current_select_q,
          {trickle_thermal_choke_en_q, trickle_usbsupply_choke_en_q,
           choke_recovery_tc_select_q, end_of_charge_action_q,
           fast_charge_en_q, fast_usbsupply_throttle_en_q,
           thermistor_monitor_en_q, battery_hot_monitor_en_q,
           battery_cold_monitor_en_q, die_temp_monitor_en_q});
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Charge sequencing: the request only asks, conditions decide
  bcc_state_e state_q, state_d;
  logic any_fault, may_run;

  assign any_fault = fault(
    {thermistor_monitor_en_q, battery_hot_monitor_en_q,
     battery_cold_monitor_en_q, die_temp_monitor_en_q},
    {i_thermistor_missing, i_batt_hot, i_batt_cold, i_die_hot});
  assign may_run = charge_request_q && i_cond_ok && !any_fault;

  always_comb begin
    state_d = state_q;
    case (state_q)
      BCC_OFF: begin
        if (may_run) begin
          state_d = BCC_TRICKLE;
        end
      end
      BCC_TRICKLE: begin
        if (!may_run) begin
          state_d = BCC_OFF;
        end else if (fast_charge_en_q && i_fast_cond) begin
          state_d = BCC_FAST;
        end
      end
      BCC_FAST: begin
        if (!may_run) begin
          state_d = BCC_OFF;
        end else if (!fast_charge_en_q || !i_fast_cond) begin
          state_d = BCC_TRICKLE;
        end else if (i_timeout) begin
          state_d = BCC_ENDED;
        end else if (i_eoc_reached && !end_of_charge_action_q) begin
          state_d = BCC_ENDED;
        end
      end
      BCC_ENDED: begin
        // Stays ended until the request drops or conditions fail
        if (!may_run) begin
          state_d = BCC_OFF;
        end
      end
      default: begin
        state_d = BCC_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= BCC_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Registered outputs, each one cycle after its cause
  logic act_d, trk_d, fst_d;
  logic tchk_d, uchk_d, thr_d;
  logic act_q, trk_q, fst_q, tchk_q, uchk_q, thr_q;
  logic [6:0] term_q;
  logic recovering;

  always_comb begin
    trk_d = (state_d == BCC_TRICKLE);
    fst_d = (state_d == BCC_FAST);
    act_d = trk_d || fst_d;
    tchk_d = trk_d && trickle_thermal_choke_en_q && i_temp_high;
    uchk_d = trk_d && trickle_usbsupply_choke_en_q && i_usb_limit;
    thr_d = fst_d && fast_usbsupply_throttle_en_q && i_usb_limit;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      act_q <= 1'b0;
      trk_q <= 1'b0;
      fst_q <= 1'b0;
      tchk_q <= 1'b0;
      uchk_q <= 1'b0;
      thr_q <= 1'b0;
      term_q <= BCC_EOC_BASE_MA;
    end else begin
      act_q <= act_d;
      trk_q <= trk_d;
      fst_q <= fst_d;
      tchk_q <= tchk_d;
      uchk_q <= uchk_d;
      thr_q <= thr_d;
      term_q <= eoc_ma(termination_current_select_q);
    end
  end

  // Step-up recovery after any choke or throttle lets go
  bcc_recovery_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_recovery (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_choke(tchk_q || uchk_q || thr_q),
    .i_long_sel(choke_recovery_tc_select_q),
    .o_recovering(recovering)
  );

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_charging_active_status = act_q;
  assign o_current_en = act_q; // Zero current unless actively charging
  assign o_trickle_mode = trk_q;
  assign o_fast_mode = fst_q;
  assign o_term_current_ma = term_q;
  assign o_thermal_choke = tchk_q;
  assign o_usb_choke = uchk_q;
  assign o_usb_throttle = thr_q;
  assign o_choke_recovering = recovering;

endmodule

// >>> rtl/bcc_pkg.sv
// Purpose: Constants for the battery charger control register block
// Assumes: 25 MHz system clock, 16-bit register port
// Notes: Mask defaults are module parameters; these are layout, fixed resets, current mapping, timing and states
package bcc_pkg;

  // Register map
  localparam logic [7:0] BCC_CTRL1_OFFSET = 8'ha8;
  localparam int BCC_DATA_W = 16;

  // Field positions in charger_control_one
  localparam int BCC_REQ_BIT = 15;
  localparam int BCC_EOC_MSB = 12;
  localparam int BCC_EOC_LSB = 10;
  localparam int BCC_TCHOKE_BIT = 9;
  localparam int BCC_UCHOKE_BIT = 8;
  localparam int BCC_RECOV_BIT = 7;
  localparam int BCC_ENDACT_BIT = 6;
  localparam int BCC_FAST_BIT = 5;
  localparam int BCC_THROT_BIT = 4;
  localparam int BCC_NTC_BIT = 3;
  localparam int BCC_HOT_BIT = 2;
  localparam int BCC_COLD_BIT = 1;
  localparam int BCC_DIE_BIT = 0;

  // Fixed reset values of non-mask fields
  localparam logic [2:0] BCC_EOC_RESET = 3'h0;
  localparam logic BCC_BIT_RESET = 1'b0;

  // Termination current code mapping, in mA
  localparam logic [6:0] BCC_EOC_BASE_MA = 7'h14;
  localparam logic [6:0] BCC_EOC_STEP_MA = 7'h0a;

  // Choke recovery time constants
  localparam int BCC_CLK_HZ = 25_000_000;
  localparam int BCC_TC_SHORT_US = 180;
  localparam int BCC_TC_LONG_MS = 20;
  localparam int BCC_TC_SHORT_CYC = BCC_TC_SHORT_US * (BCC_CLK_HZ / 1_000_000);
  localparam int BCC_TC_LONG_CYC = BCC_TC_LONG_MS * (BCC_CLK_HZ / 1_000) + 1;
  localparam int BCC_TC_W = 20;

  // Charger sequencing states
  typedef enum logic [1:0] {
    BCC_OFF,
    BCC_TRICKLE,
    BCC_FAST,
    BCC_ENDED
  } bcc_state_e;

endpackage

// >>> rtl/bcc_recovery_timer.sv
// Purpose: Step-up recovery timer after a charger choke is released
// Assumes: Choke level synchronous to i_clk
// Notes: Restarts whenever a choke reasserts during recovery
`timescale 1ns/1ps
module bcc_recovery_timer
  import bcc_pkg::*;
#(
  parameter int SHORT_CYC = BCC_TC_SHORT_CYC,
  parameter int LONG_CYC = BCC_TC_LONG_CYC
) (
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_choke, // Any choke currently applied
  input wire logic i_long_sel, // Select the long time constant
  output logic o_recovering // Current is stepping back up
);

  logic [BCC_TC_W-1:0] cnt_q, cnt_d;
  logic rec_q, rec_d;
  logic choke_q;

  // Load while a choke is held, count down to full current after release
  always_comb begin
    cnt_d = cnt_q;
    rec_d = rec_q;
    if (i_choke) begin
      rec_d = 1'b0;
      cnt_d = i_long_sel ? BCC_TC_W'(LONG_CYC - 1) : BCC_TC_W'(SHORT_CYC - 1);
    end else if (rec_q) begin
      if (cnt_q == '0) begin
        rec_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
    // Release edge: choke was held last cycle, start the step-up
    if (!i_choke && choke_q) begin
      rec_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      rec_q <= 1'b0;
      choke_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rec_q <= rec_d;
      choke_q <= i_choke;
    end
  end

  assign o_recovering = rec_q;

endmodule

// >>> dv/bcc_charger_ctrl_assertions.sv
// Purpose: Port-level checks for the charger control register block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Sticky fast-ready and recovery length are tracked in helper logic
`timescale 1ns/1ps
module bcc_charger_ctrl_checker
  import bcc_pkg::*;
#(
  parameter int SHORT_CYC = BCC_TC_SHORT_CYC,
  parameter int LONG_CYC = BCC_TC_LONG_CYC
) (
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic [7:0] i_reg_addr, // Register address
  input wire logic i_reg_rd, // Read strobe
  input wire logic [15:0] o_reg_rdata, // Read data
  input wire logic o_reg_rvalid, // Read answer
  input wire logic i_fast_ready, // Fast charge ready
  input wire logic i_fast_cond, // Fast conditions valid
  input wire logic i_cond_ok, // Charging conditions
  input wire logic i_temp_high, // Thermal choke demand
  input wire logic i_usb_limit, // USB supply at limit
  input wire logic o_charging_active_status, // Charging runs
  input wire logic o_current_en, // Current allowed
  input wire logic o_trickle_mode, // Trickle charge
  input wire logic o_fast_mode, // Fast charge
  input wire logic o_thermal_choke, // Thermal choking
  input wire logic o_usb_choke, // USB choking
  input wire logic o_usb_throttle, // USB throttling
  input wire logic o_choke_recovering // Stepping back up
);
  logic seen_d, seen_q;
  logic [31:0] rec_d, rec_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Fast-ready is sticky; recovery length counts consecutive cycles
  always_comb begin
    seen_d = seen_q | i_fast_ready;
    rec_d = o_choke_recovering ? rec_q + 32'h1 : 32'h0;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seen_q <= 1'b0;
      rec_q <= 32'h0;
    end else begin
      seen_q <= seen_d;
      rec_q <= rec_d;
    end
  end

  read_answer_a: assert property (o_reg_rvalid == $past(i_reg_rd))
    else $error("read answer not one cycle after strobe");
  unmapped_read_a: assert property (i_reg_rd && i_reg_addr != BCC_CTRL1_OFFSET |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read returned nonzero");
  reserved_zero_a: assert property (o_reg_rvalid |-> o_reg_rdata[14:13] == 2'b00)
    else $error("reserved bits read nonzero");
  fast_lock_a: assert property (i_reg_rd && !seen_q |=> !o_reg_rdata[BCC_FAST_BIT])
    else $error("fast enable set before ready");
  fast_gate_a: assert property (o_fast_mode |-> seen_q && $past(i_fast_cond))
    else $error("fast charge without ready or conditions");
  status_tie_a: assert property (o_current_en == o_charging_active_status && !(o_trickle_mode && o_fast_mode)
    && o_charging_active_status == (o_trickle_mode || o_fast_mode))
    else $error("active status disagrees with mode");
  cond_drop_a: assert property (!i_cond_ok |=> !o_current_en)
    else $error("current kept without conditions");
  thermal_choke_a: assert property (o_thermal_choke |-> o_trickle_mode && $past(i_temp_high))
    else $error("thermal choke outside trickle or demand");
  usb_choke_a: assert property (o_usb_choke |-> o_trickle_mode && $past(i_usb_limit))
    else $error("usb choke outside trickle or limit");
  usb_throttle_a: assert property (o_usb_throttle |-> o_fast_mode && $past(i_usb_limit))
    else $error("throttle outside fast or limit");
  recover_bound_a: assert property (rec_q <= 32'(LONG_CYC))
    else $error("recovery lasted beyond long constant");

  cover property (o_fast_mode && o_usb_throttle);
  cover property ($fell(o_choke_recovering));
  cover property (o_thermal_choke && o_usb_choke);
endmodule

bind bcc_charger_ctrl bcc_charger_ctrl_checker #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_chk (
  .i_clk, .i_rstn, .i_reg_addr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_fast_ready, .i_fast_cond,
  .i_cond_ok, .i_temp_high, .i_usb_limit, .o_charging_active_status, .o_current_en, .o_trickle_mode,
  .o_fast_mode, .o_thermal_choke, .o_usb_choke, .o_usb_throttle, .o_choke_recovering);

// >>> dv/bcc_host_model.sv
// Purpose: Host processor model on the charger register port
// Assumes: Strobes taken on the rising edge, read answer one cycle later
// Notes: A released bus shows the inverse of its last value
`timescale 1ns/1ps
module bcc_host_model (
  input wire logic i_clk, // System clock
  output logic [7:0] o_addr, // Register address
  output logic o_wr, // Write strobe
  output logic o_rd, // Read strobe
  output logic [15:0] o_wdata, // Write data
  input wire logic [15:0] i_rdata, // Read data
  input wire logic i_rvalid // Read answer
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end

  // Inverted idle values keep a stale bus from passing for a fresh one
  task automatic release_bus();
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~o_addr;
    o_wdata <= ~o_wdata;
  endtask

  // One-cycle write strobe; key-protected fields land only while the key is open
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    release_bus();
  endtask

  // One-cycle read strobe, answer awaited for a bounded time
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    int n;
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    release_bus();
    d = 'x;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_rvalid !== 1'b1 && n < 4);
    if (i_rvalid === 1'b1) d = i_rdata;
  endtask
endmodule

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the charger control register block
// Assumes: Host model drives the register port; bench drives the status inputs
// Notes: Recovery times shortened through parameters; expectations are fixed cycle counts chosen against them
`timescale 1ns/1ps
module testbench;
  import bcc_pkg::*;
  localparam int SC = 20;
  localparam int LC = 50;
  logic i_clk, i_rstn, i_reg_wr, i_reg_rd, o_reg_rvalid;
  logic [7:0] i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, cr, rv, d;
  logic i_key_unlocked, i_psm_reset, i_fast_ready, i_cond_ok, i_fast_cond, i_eoc_reached, i_timeout;
  logic i_thermistor_missing, i_batt_hot, i_batt_cold, i_die_hot, i_temp_high, i_usb_limit;
  logic o_charging_active_status, o_current_en, o_trickle_mode, o_fast_mode;
  logic o_thermal_choke, o_usb_choke, o_usb_throttle, o_choke_recovering;
  logic [6:0] o_term_current_ma;
  logic [31:0] seed;
  int miscompares, compares;

  bcc_host_model host (.i_clk, .o_addr(i_reg_addr), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata),
    .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid));
  bcc_charger_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC)) dut (.i_clk, .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_rd,
    .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_key_unlocked, .i_psm_reset, .i_fast_ready, .i_cond_ok,
    .i_fast_cond, .i_thermistor_missing, .i_batt_hot, .i_batt_cold, .i_die_hot, .i_temp_high, .i_usb_limit,
    .i_eoc_reached, .i_timeout, .o_charging_active_status, .o_current_en, .o_trickle_mode, .o_fast_mode,
    .o_term_current_ma, .o_thermal_choke, .o_usb_choke, .o_usb_throttle, .o_choke_recovering);

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Locked writes reach only bits 3:1; fast enable needs ready seen first
  function automatic logic [15:0] exp_wr(input logic [15:0] old, input logic [15:0] v, input logic k);
    logic [15:0] m;
    m = k ? 16'h9fff : 16'h000e;
    return (old & ~m) | (v & m);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    host.read_reg(a, rv);
    check(rv, e);
  endtask

  task automatic wreg(input logic [15:0] v);
    cr = v;
    host.write_reg(8'ha8, v);
  endtask

  // Three edges let an input cross into the state and output registers
  task automatic st(input logic [6:0] e);
    repeat (3) @(posedge i_clk);
    check({9'h0, o_charging_active_status, o_current_en, o_trickle_mode, o_fast_mode, o_thermal_choke,
      o_usb_choke, o_usb_throttle}, {9'h0, e});
  endtask

  task automatic recov(input int n, input logic e);
    repeat (n) @(posedge i_clk);
    check({15'h0, o_choke_recovering}, {15'h0, e});
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog sized well past the roughly four hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge i_clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    i_rstn = 1'b0;
    {i_key_unlocked, i_psm_reset, i_fast_ready, i_cond_ok, i_fast_cond, i_eoc_reached, i_timeout} = 7'h0;
    {i_thermistor_missing, i_batt_hot, i_batt_cold, i_die_hot, i_temp_high, i_usb_limit} = 6'h0;
    seed = 32'h7d93ae8b;
    miscompares = 0;
    compares = 0;
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    check({9'h0, o_term_current_ma}, 16'h0014);
    rd_chk(8'ha8, 16'h800f);
    rd_chk(8'ha9, 16'h0000);
    $display("test reset values done");
    host.write_reg(8'ha8, 16'h0000);
    rd_chk(8'ha8, 16'h8001);
    host.write_reg(8'ha7, 16'hffff);
    rd_chk(8'ha8, 16'h8001);
    $display("test key lock done");
    i_key_unlocked <= 1'b1;
    host.write_reg(8'ha8, 16'hffff);
    rd_chk(8'ha8, 16'h9fdf);
    i_fast_ready <= 1'b1;
    host.write_reg(8'ha8, 16'hffff);
    rd_chk(8'ha8, 16'h9fff);
    $display("test fast lock done");
    cr = 16'h9fff;
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 16'h1c00 : (i == 1) ? 16'h0000 : seed[15:0];
      i_key_unlocked <= (i < 2) | seed[16];
      i_fast_ready <= seed[17];
      host.write_reg(8'ha8, d);
      cr = exp_wr(cr, d, (i < 2) | seed[16]);
      rd_chk(8'ha8, cr);
      check({9'h0, o_term_current_ma}, 16'h0014 + 16'(cr[12:10]) * 16'h000a);
    end
    $display("test random writes done");
    i_key_unlocked <= 1'b1;
    host.write_reg(8'ha8, 16'hffff);
    i_psm_reset <= 1'b1;
    @(posedge i_clk);
    i_psm_reset <= 1'b0;
    rd_chk(8'ha8, 16'h9c0f);
    $display("test sequencer reset done");
    wreg(16'h833f);
    {i_cond_ok, i_usb_limit, i_temp_high} <= 3'b111;
    st(7'b1110110);
    i_fast_cond <= 1'b1;
    st(7'b1101001);
    {i_usb_limit, i_temp_high} <= 2'b00;
    recov(6, 1'b1);
    recov(34, 1'b0);
    wreg(cr | 16'h0080);
    i_usb_limit <= 1'b1;
    st(7'b1101001);
    i_usb_limit <= 1'b0;
    recov(40, 1'b1);
    recov(30, 1'b0);
    $display("test choke recovery done");
    i_eoc_reached <= 1'b1;
    st(7'b0000000);
    wreg(cr | 16'h0040);
    i_cond_ok <= 1'b0;
    st(7'b0000000);
    i_cond_ok <= 1'b1;
    st(7'b1101000);
    i_timeout <= 1'b1;
    st(7'b0000000);
    {i_timeout, i_eoc_reached, i_fast_cond, i_cond_ok} <= 4'h0;
    st(7'b0000000);
    i_cond_ok <= 1'b1;
    st(7'b1110000);
    $display("test end of charge done");
    for (int k = 0; k < 4; k++) begin
      {i_thermistor_missing, i_batt_hot, i_batt_cold, i_die_hot} <= 4'h8 >> k;
      st(7'b0000000);
      host.write_reg(8'ha8, cr & ~(16'h0008 >> k));
      st(7'b1110000);
      host.write_reg(8'ha8, cr);
    end
    {i_thermistor_missing, i_batt_hot, i_batt_cold, i_die_hot} <= 4'h0;
    $display("test monitor enables done");
    wreg(cr & ~16'h0020);
    i_fast_cond <= 1'b1;
    st(7'b1110000);
    wreg(cr & ~16'h8000);
    st(7'b0000000);
    $display("test request and fast gate done");
    print_verdict();
  end
endmodule
